// ---- euart.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "euart_regs.svh"

module euart_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = `EUART_FIFO_DEPTH
) (
   input  wire logic             clk_sys,
   input  wire logic             rst_b,
   input  wire logic             clk_en,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output var  logic             in_ready,
   output var  logic [WIDTH-1:0] out_data,
   output var  logic             out_valid,
   input  wire logic             out_ready
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0
       || WIDTH < 1) begin : g_bad_param
      $error("euart_fifo: DEPTH must be a power of two >= 2");
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wp_q;
   logic [AW-1:0]    rp_q;
   logic [AW:0]      cnt_q;
   logic [AW:0]      cnt_d;
   logic             push;
   logic             pop;
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem[rp_q];
   always_comb begin
      cnt_d = cnt_q;
      if (push && !pop) cnt_d = cnt_q + 1'b1;
      if (pop && !push) cnt_d = cnt_q - 1'b1;
   end
   always_ff @(posedge clk_sys) begin
      if (clk_en && push) mem[wp_q] <= in_data;
   end
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wp_q     <= '0;
         rp_q     <= '0;
         cnt_q    <= '0;
         in_ready <= 1'b0;
      end else if (clk_en) begin
         if (push) wp_q <= wp_q + 1'b1;
         if (pop) rp_q <= rp_q + 1'b1;
         cnt_q    <= cnt_d;
         in_ready <= (cnt_d != (AW+1)'(DEPTH));
      end
   end
endmodule : euart_fifo

module euart (
   input  wire logic                     clk_sys,
   input  wire logic                     rst_b,
   input  wire logic                     clk_en,
   input  wire euart_pkg::euart_mode_type mode,
   input  wire logic                     multiproc_enable,
   input  wire logic                     rx_enable,
   input  wire logic                     baud_double_bit,
   input  wire logic                     tx_timer_select,
   input  wire logic                     rx_timer_select,
   input  wire logic                     timer_b_ext_sel,
   input  wire logic                     timer_b_pin,
   input  wire logic [7:0]               timer_b_reload_high,
   input  wire logic [7:0]               timer_b_reload_low,
   input  wire logic                     timer_d_tick,
   input  wire logic [7:0]               timer_d_reload_high,
   input  wire logic [7:0]               timer_d_reload_low,
   input  wire logic [7:0]               slave_address,
   input  wire logic [7:0]               slave_address_mask,
   input  wire logic                     tx_ninth_bit,
   input  wire logic [7:0]               wr_data,
   input  wire logic                     wr_valid,
   output var  logic                     wr_ready,
   input  wire logic                     tx_done_clr,
   output var  logic                     tx_done_flag,
   output var  logic                     txd,
   input  wire logic                     rxd,
   input  wire logic                     rx_done_clr,
   output var  logic                     rx_done_flag,
   output var  logic                     rx_ninth_bit,
   output var  logic [7:0]               serial_buffer,
   output var  logic                     shift_clk
);
   import euart_pkg::*;
   default clocking cb_sys @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   function automatic logic maj3(input logic a, input logic b,
                                 input logic c);
      maj3 = (a & b) | (a & c) | (b & c);
   endfunction : maj3

   function automatic logic addr_match(input logic [7:0] byte_in,
                                       input logic [7:0] addr,
                                       input logic [7:0] mask);
      logic [7:0] bcast;
      bcast = addr | mask;
      addr_match = (((byte_in ^ addr) & mask) == 8'h00)
                || (((~byte_in) & bcast) == 8'h00);
   endfunction : addr_match

   function automatic logic [15:0] tmr_next(input logic [15:0] cnt,
                                            input logic [15:0] rld);
      tmr_next = (cnt == `EUART_TMR_TOP) ? rld : cnt + 16'h0001;
   endfunction : tmr_next

   // Input synchronisers
   logic rxd_s1_q, rxd_s2_q, rxd_s3_q;
   logic tbp_s1_q, tbp_s2_q, tbp_s3_q;
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         {rxd_s1_q, rxd_s2_q, rxd_s3_q} <= 3'h7;
         {tbp_s1_q, tbp_s2_q, tbp_s3_q} <= 3'h0;
      end else if (clk_en) begin
         {rxd_s3_q, rxd_s2_q, rxd_s1_q} <= {rxd_s2_q, rxd_s1_q, rxd};
         {tbp_s3_q, tbp_s2_q, tbp_s1_q} <= {tbp_s2_q, tbp_s1_q,
                                            timer_b_pin};
      end
   end

   // Baud timers
   logic [15:0] tb_cnt_q, td_cnt_q;
   logic        tb_half_q, td_half_q;
   logic        tb_inc, tb_ovf, td_ovf, tb_tick, td_tick;
   assign tb_inc  = (tx_timer_select || rx_timer_select)
                 && (!timer_b_ext_sel || (tbp_s2_q && !tbp_s3_q));
   assign tb_ovf  = tb_inc && (tb_cnt_q == `EUART_TMR_TOP);
   assign td_ovf  = timer_d_tick && (td_cnt_q == `EUART_TMR_TOP);
   assign tb_tick = tb_ovf && (timer_b_ext_sel || tb_half_q);
   assign td_tick = td_ovf && (baud_double_bit || td_half_q);
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         tb_cnt_q  <= '0;
         tb_half_q <= 1'b0;
      end else if (clk_en && tb_inc) begin
         tb_cnt_q  <= tmr_next(tb_cnt_q,
                               {timer_b_reload_high, timer_b_reload_low});
         if (tb_ovf) tb_half_q <= !tb_half_q;
      end
   end
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         td_cnt_q  <= '0;
         td_half_q <= 1'b0;
      end else if (clk_en && timer_d_tick) begin
         td_cnt_q  <= tmr_next(td_cnt_q,
                               {timer_d_reload_high, timer_d_reload_low});
         if (td_ovf) td_half_q <= !td_half_q;
      end
   end

   // Fixed-rate dividers
   logic [2:0] m2_cnt_q;
   logic [3:0] m0_cnt_q;
   logic       m2_tick, m0_tick;
   assign m2_tick = (m2_cnt_q == 3'h0);
   assign m0_tick = (m0_cnt_q == 4'h0);
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         m2_cnt_q <= '0;
      end else if (clk_en) begin
         if (m2_tick)
            m2_cnt_q <= (baud_double_bit ? `EUART_M2_DIV_FST
                                         : `EUART_M2_DIV_SLW) - 3'h1;
         else
            m2_cnt_q <= m2_cnt_q - 3'h1;
      end
   end
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         m0_cnt_q  <= '0;
         shift_clk <= 1'b0;
      end else if (clk_en) begin
         if (m0_tick)
            m0_cnt_q <= (multiproc_enable ? `EUART_M0_DIV_FST
                                          : `EUART_M0_DIV_SLW) - 4'h1;
         else
            m0_cnt_q <= m0_cnt_q - 4'h1;
         shift_clk <= m0_tick && (mode == EU_MODE_SYNC);
      end
   end

   logic tx_tick, rx_tick, frame11;
   assign frame11 = (mode == EU_MODE_FIX11) || (mode == EU_MODE_VAR11);
   always_comb begin
      tx_tick = 1'b0;
      rx_tick = 1'b0;
      if (mode == EU_MODE_FIX11) begin
         tx_tick = m2_tick;
         rx_tick = m2_tick;
      end else if (mode != EU_MODE_SYNC) begin
         tx_tick = tx_timer_select ? tb_tick : td_tick;
         rx_tick = rx_timer_select ? tb_tick : td_tick;
      end
   end

   // Transmitter
   logic [8:0] fifo_data;
   logic       fifo_valid, fifo_pop;
   euart_fifo #(.WIDTH(9), .DEPTH(`EUART_FIFO_DEPTH)) u_txq (
      .clk_sys  (clk_sys),
      .rst_b    (rst_b),
      .clk_en   (clk_en),
      .in_data  ({tx_ninth_bit, wr_data}),
      .in_valid (wr_valid),
      .in_ready (wr_ready),
      .out_data (fifo_data),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop)
   );
   logic [3:0] tx_cnt_q, tx_left_q;
   logic [9:0] tx_sr_q;
   logic       tx_roll, tx_stop_ev;
   assign tx_roll    = tx_tick && (tx_cnt_q == `EUART_OVS_LAST);
   assign fifo_pop   = clk_en && tx_roll && (tx_left_q == 4'h0)
                    && (mode != EU_MODE_SYNC);
   assign tx_stop_ev = clk_en && tx_roll && (tx_left_q == 4'h1);
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         tx_cnt_q <= '0;
      end else if (clk_en && tx_tick) begin
         tx_cnt_q <= tx_cnt_q + 4'h1;
      end
   end
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         tx_sr_q   <= '1;
         tx_left_q <= '0;
         txd       <= 1'b1;
      end else if (clk_en && tx_roll) begin
         if (tx_left_q != 4'h0) begin
            txd       <= tx_sr_q[0];
            tx_sr_q   <= {1'b1, tx_sr_q[9:1]};
            tx_left_q <= tx_left_q - 4'h1;
         end else if (fifo_pop && fifo_valid) begin
            txd <= 1'b0;
            if (frame11) begin
               tx_sr_q   <= {1'b1, fifo_data};
               tx_left_q <= `EUART_TX_LEFT_11;
            end else begin
               tx_sr_q   <= {2'b11, fifo_data[7:0]};
               tx_left_q <= `EUART_TX_LEFT_10;
            end
         end else begin
            txd <= 1'b1;
         end
      end
   end
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         tx_done_flag <= 1'b0;
      end else if (clk_en) begin
         if (tx_stop_ev) tx_done_flag <= 1'b1;
         else if (tx_done_clr) tx_done_flag <= 1'b0;
      end
   end

   // Receiver
   euart_rx_state_type rx_st_q;
   logic [3:0] rx_cnt_q, rx_left_q;
   logic [1:0] rx_smp_q;
   logic [8:0] rx_sr_q;
   logic       rx_fall, bit_ev, bit_val, accept10, accept11;
   assign rx_fall  = rxd_s3_q && !rxd_s2_q;
   assign bit_ev   = clk_en && rx_tick && (rx_cnt_q == `EUART_SMP_C)
                  && (rx_st_q != RX_IDLE);
   assign bit_val  = maj3(rx_smp_q[1], rx_smp_q[0], rxd_s2_q);
   assign accept10 = bit_ev && (rx_st_q == RX_STOP) && !frame11
                  && !rx_done_flag
                  && (!multiproc_enable || bit_val);
   assign accept11 = bit_ev && (rx_st_q == RX_STOP) && frame11
                  && !rx_done_flag
                  && (!multiproc_enable || (rx_sr_q[8]
                  && addr_match(rx_sr_q[7:0], slave_address,
                                slave_address_mask)));
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rx_cnt_q <= '0;
         rx_smp_q <= '0;
      end else if (clk_en) begin
         if (rx_st_q == RX_IDLE && rx_enable && rx_fall)
            rx_cnt_q <= '0;
         else if (rx_tick)
            rx_cnt_q <= rx_cnt_q + 4'h1;
         if (rx_tick && rx_cnt_q == `EUART_SMP_A)
            rx_smp_q[1] <= rxd_s2_q;
         if (rx_tick && rx_cnt_q == `EUART_SMP_B)
            rx_smp_q[0] <= rxd_s2_q;
      end
   end
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rx_st_q   <= RX_IDLE;
         rx_left_q <= '0;
         rx_sr_q   <= '0;
      end else if (clk_en) begin
         if (!rx_enable || mode == EU_MODE_SYNC) begin
            rx_st_q <= RX_IDLE;
         end else begin
            case (rx_st_q)
               RX_IDLE: begin
                  if (rx_fall) rx_st_q <= RX_START;
               end
               RX_START: begin
                  if (bit_ev) begin
                     rx_st_q   <= bit_val ? RX_IDLE : RX_DATA;
                     rx_left_q <= frame11 ? `EUART_RX_DATA_11
                                          : `EUART_RX_DATA_10;
                  end
               end
               RX_DATA: begin
                  if (bit_ev) begin
                     rx_sr_q   <= {bit_val, rx_sr_q[8:1]};
                     rx_left_q <= rx_left_q - 4'h1;
                     if (rx_left_q == 4'h1) rx_st_q <= RX_STOP;
                  end
               end
               RX_STOP: begin
                  if (bit_ev) rx_st_q <= RX_IDLE;
               end
               default: rx_st_q <= RX_IDLE;
            endcase
         end
      end
   end
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rx_done_flag  <= 1'b0;
         rx_ninth_bit  <= 1'b0;
         serial_buffer <= '0;
      end else if (clk_en) begin
         if (accept10) begin
            serial_buffer <= rx_sr_q[8:1];
            rx_ninth_bit  <= bit_val;
         end else if (accept11) begin
            serial_buffer <= rx_sr_q[7:0];
            rx_ninth_bit  <= rx_sr_q[8];
         end
         if (accept10 || accept11) rx_done_flag <= 1'b1;
         else if (rx_done_clr) rx_done_flag <= 1'b0;
      end
   end

   // Checks
   rx_acc10_a: assert property (accept10 |=> rx_done_flag
      && serial_buffer == $past(rx_sr_q[8:1]))
      else $error("10-bit frame not stored");
   rx_hold_a: assert property (rx_done_flag && !rx_done_clr
      |=> $stable(serial_buffer))
      else $error("buffer changed while done flag set");
   rx_ninth_a: assert property (accept11 |=>
      rx_ninth_bit == $past(rx_sr_q[8]))
      else $error("ninth bit not stored");
   m2_rate_a: assert property (m2_tick && clk_en &&
      !baud_double_bit ##1 clk_en[*3]
      |-> !$past(m2_tick, 1) && !$past(m2_tick, 2) && !m2_tick
      ##1 m2_tick)
      else $error("fixed-rate divider period wrong");
   tx_start_a: assert property (fifo_pop && fifo_valid
      |=> !txd && tx_left_q != 4'h0)
      else $error("start bit not sent after rollover");
   tx_done_a: assert property (tx_stop_ev
      |=> tx_done_flag && txd)
      else $error("done flag missing at stop bit");
   rx_edge_a: assert property (clk_en && rx_st_q == RX_IDLE
      && rx_enable && rx_fall && mode != EU_MODE_SYNC
      |=> rx_cnt_q == 4'h0 && rx_st_q == RX_START)
      else $error("edge did not restart bit counter");
   rx_abort_a: assert property (bit_ev && rx_st_q == RX_START
      && bit_val && rx_enable |=> rx_st_q == RX_IDLE)
      else $error("bad start bit not aborted");
   rx_mp11_a: assert property (accept11 && multiproc_enable
      |=> rx_ninth_bit)
      else $error("data byte raised done flag");
   rx_en_a: assert property (clk_en && !rx_enable
      |=> rx_st_q == RX_IDLE)
      else $error("receiver active while disabled");
   rx_acc10_c: cover property (@(posedge clk_sys) disable iff (!rst_b)
      accept10 && multiproc_enable);
   tx_frame_c: cover property (@(posedge clk_sys) disable iff (!rst_b)
      tx_stop_ev);
   rx_acc_c: cover property (@(posedge clk_sys) disable iff (!rst_b)
      accept11 && multiproc_enable);
   rx_abort_c: cover property (@(posedge clk_sys) disable iff (!rst_b)
      bit_ev && rx_st_q == RX_START && bit_val);
   fifo_full_c: cover property (@(posedge clk_sys) disable iff (!rst_b)
      !wr_ready);
endmodule : euart
`default_nettype wire

// ---- euart_regs.svh ----
// Overview of operation
// - 10-bit frame accepted only if flag clear, and stop ok or multiprocessor off
// - After frame, wait edge; hold until flag cleared
// - 11-bit frame: start, 8 data LSB first, ninth, stop
// - 11-bit: ninth bit stored, stop bit discarded
// - Fixed 11-bit rate: clock/64, or /32 doubled
// - Buffer write loads data and ninth bit together
// - Transmit starts after next divide-by-16 rollover
// - Start, data, stop; done flag at stop start
// - Receive only when enabled; 16x sampled falling edge
// - Falling edge resets receive divide-by-16 counter
// - Samples at states 7, 8, 9; majority vote
// - Start bit not zero aborts reception
// - 11-bit accept: flag clear; ninth set, address match only if multiprocessor
// - Variable 11-bit mode: fixed framing, timer rate
// - Synchronous mode: clock/12, or /4 with enable
// - Timer selects pick timer B, else timer D
// - Timer B rate: /32 internal, /16 external input
// - Timer D rate doubled by baud double bit
// - 11-bit multiprocessor: done only if ninth set
// - 10-bit multiprocessor: done only if stop valid
// - Given address compares only mask-enabled bits
// - Broadcast address OR of address and mask matches
// - Address and mask reset to zero; here both are input ports with no reset
`ifndef EUART_REGS_SVH
`define EUART_REGS_SVH
`define EUART_OVS_LAST   4'hf
`define EUART_SMP_A      4'h7
`define EUART_SMP_B      4'h8
`define EUART_SMP_C      4'h9
`define EUART_M2_DIV_SLW 3'h4
`define EUART_M2_DIV_FST 3'h2
`define EUART_M0_DIV_SLW 4'hc
`define EUART_M0_DIV_FST 4'h4
`define EUART_TX_LEFT_10 4'h9
`define EUART_TX_LEFT_11 4'ha
`define EUART_RX_DATA_10 4'h8
`define EUART_RX_DATA_11 4'h9
`define EUART_FIFO_DEPTH 8
`define EUART_TMR_TOP    16'hffff
`define EUART_ADDR_RST   8'h00
`endif

// ---- euart_pkg.sv ----
package euart_pkg;
   typedef enum logic [1:0] {
      EU_MODE_SYNC  = 2'h0,
      EU_MODE_VAR10 = 2'h1,
      EU_MODE_FIX11 = 2'h2,
      EU_MODE_VAR11 = 2'h3
   } euart_mode_type;
   typedef enum logic [1:0] {
      RX_IDLE  = 2'h0,
      RX_START = 2'h1,
      RX_DATA  = 2'h3,
      RX_STOP  = 2'h2
   } euart_rx_state_type;
endpackage : euart_pkg

// ---- euart_serial_node.sv ----
`timescale 1ns/1ps
`default_nettype none

module euart_serial_node (
   input  wire logic txd,
   output var  logic rxd
);
   int         bit_ns = 320;
   logic [9:0] got_q[$];
   logic [8:0] shreg;

   initial begin
      rxd = 1'b1;
   end

   // Start, eight data bits LSB first, ninth bit, stop
   task automatic send(input logic [7:0] d, input logic n, input logic stp);
      logic [10:0] fr;
      fr = {stp, n, d, 1'b0};
      for (int i = 0; i < 11; i++) begin
         rxd = fr[i];
         #(bit_ns);
      end
      rxd = 1'b1;
   endtask : send

   // Low pulse too short to pass as a start bit
   task automatic glitch(input int ns);
      rxd = 1'b0;
      #(ns);
      rxd = 1'b1;
   endtask : glitch

   // Samples each incoming bit at its centre; stores stop, ninth, data
   always begin
      @(negedge txd);
      #(bit_ns / 2);
      if (txd === 1'b0) begin
         for (int i = 0; i < 9; i++) begin
            #(bit_ns);
            shreg[i] = txd;
         end
         #(bit_ns);
         got_q.push_back({txd, shreg});
      end
   end
endmodule : euart_serial_node

`default_nettype wire

// ---- euart_bench.sv ----
`timescale 1ns/1ps
`default_nettype none

module euart_bench;
   import euart_pkg::*;
   logic           clk_sys, rst_b, clk_en, multiproc_enable, rx_enable;
   logic           baud_double_bit, tx_timer_select, rx_timer_select;
   logic           timer_b_ext_sel, timer_b_pin, timer_d_tick;
   logic [7:0]     slave_address, slave_address_mask, wr_data;
   logic           tx_ninth_bit, wr_valid, wr_ready, tx_done_clr;
   logic           tx_done_flag, txd, rxd, rx_done_clr, rx_done_flag;
   logic           rx_ninth_bit, shift_clk;
   logic [7:0]     serial_buffer;
   euart_mode_type mode;
   int             err_count, tests_run, stalls;
   logic [15:0]    tb_reload, td_reload;

   euart DUT (
      .clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en), .mode(mode),
      .multiproc_enable(multiproc_enable), .rx_enable(rx_enable),
      .baud_double_bit(baud_double_bit), .tx_timer_select(tx_timer_select),
      .rx_timer_select(rx_timer_select), .timer_b_ext_sel(timer_b_ext_sel),
      .timer_b_pin(timer_b_pin), .timer_b_reload_high(tb_reload[15:8]),
      .timer_b_reload_low(tb_reload[7:0]), .timer_d_tick(timer_d_tick),
      .timer_d_reload_high(td_reload[15:8]),
      .timer_d_reload_low(td_reload[7:0]),
      .slave_address(slave_address), .slave_address_mask(slave_address_mask),
      .tx_ninth_bit(tx_ninth_bit), .wr_data(wr_data), .wr_valid(wr_valid),
      .wr_ready(wr_ready), .tx_done_clr(tx_done_clr),
      .tx_done_flag(tx_done_flag), .txd(txd), .rxd(rxd),
      .rx_done_clr(rx_done_clr), .rx_done_flag(rx_done_flag),
      .rx_ninth_bit(rx_ninth_bit), .serial_buffer(serial_buffer),
      .shift_clk(shift_clk));
   euart_serial_node node (.txd(txd), .rxd(rxd));

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   // External timer B input: one rising edge every two clocks
   always @(negedge clk_sys) begin
      if (timer_b_ext_sel) timer_b_pin <= ~timer_b_pin;
   end

   task automatic report_and_stop();
      if (err_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : report_and_stop

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   // Holds the word until wr_ready is seen, then lets the edge take it
   task automatic wr_word(input logic [7:0] d, input logic n);
      int cnt;
      @(negedge clk_sys);
      wr_data = d;
      tx_ninth_bit = n;
      wr_valid = 1'b1;
      cnt = 0;
      while (wr_ready !== 1'b1 && cnt < 5000) begin
         stalls++;
         cnt++;
         @(negedge clk_sys);
      end
      if (cnt >= 5000) err_count++;
      @(posedge clk_sys);
   endtask : wr_word

   task automatic pulse_clr();
      @(negedge clk_sys);
      rx_done_clr = 1'b1;
      tx_done_clr = 1'b1;
      @(negedge clk_sys);
      rx_done_clr = 1'b0;
      tx_done_clr = 1'b0;
   endtask : pulse_clr

   task automatic wait_q(input int n);
      for (int i = 0; i < 30000 && node.got_q.size() < n; i++)
         @(negedge clk_sys);
      check(node.got_q.size() >= n, 16'h1);
   endtask : wait_q

   task automatic set_rate(input logic dbl);
      @(negedge clk_sys);
      baud_double_bit = dbl;
      node.bit_ns = dbl ? 320 : 640;
   endtask : set_rate

   task automatic t_tx(input logic dbl, input logic [7:0] d, input logic n);
      set_rate(dbl);
      pulse_clr();
      node.got_q.delete();
      wr_word(d, n);
      @(negedge clk_sys);
      wr_valid = 1'b0;
      wait_q(1);
      check(node.got_q.pop_front(), {6'h0, 1'b1, n, d});
      check(tx_done_flag, 16'h1);
   endtask : t_tx

   // Sends one frame and compares the receive side's latched state
   task automatic rx_one(input logic [7:0] d, input logic n,
                         input logic [9:0] exp);
      node.send(d, n, 1'b1);
      repeat (4) @(negedge clk_sys);
      check({rx_done_flag, rx_ninth_bit, serial_buffer}, exp);
   endtask : rx_one

   task automatic t_rx(input logic dbl);
      set_rate(dbl);
      multiproc_enable = 1'b0;
      pulse_clr();
      rx_one(8'h3c, 1'b1, {2'b11, 8'h3c});
      rx_one(8'h77, 1'b0, {2'b11, 8'h3c});
      pulse_clr();
      check(rx_done_flag, 16'h0);
   endtask : t_rx

   task automatic t_glitch();
      @(negedge clk_sys);
      rx_enable = 1'b0;
      node.send(8'h99, 1'b1, 1'b1);
      repeat (4) @(negedge clk_sys);
      check(rx_done_flag, 16'h0);
      rx_enable = 1'b1;
      node.glitch(60);
      // Long enough for a wrongly kept frame of ones to complete
      #(12 * node.bit_ns);
      check(rx_done_flag, 16'h0);
      rx_one(8'h5a, 1'b0, {2'b10, 8'h5a});
      pulse_clr();
   endtask : t_glitch

   task automatic t_multi();
      logic [15:0] am[7] = '{16'h0000, 16'ha4fa, 16'ha4fa, 16'ha4fa,
                             16'ha4fa, 16'ha4fa, 16'ha4fa};
      logic [7:0]  by[7] = '{8'h13, 8'ha0, 8'ha0, 8'ha2, 8'hff, 8'h7f, 8'ha5};
      logic        nb[7] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
      logic        ok[7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
      logic [7:0]  last;
      logic        lastn;
      last = 8'h5a;
      lastn = 1'b0;
      multiproc_enable = 1'b1;
      for (int i = 0; i < 7; i++) begin
         @(negedge clk_sys);
         {slave_address, slave_address_mask} = am[i];
         if (ok[i]) begin
            last  = by[i];
            lastn = nb[i];
         end
         rx_one(by[i], nb[i], {ok[i], lastn, last});
         pulse_clr();
      end
      multiproc_enable = 1'b0;
   endtask : t_multi

   task automatic t_fifo();
      node.got_q.delete();
      stalls = 0;
      for (int i = 0; i < 10; i++) wr_word(8'h10 + i[7:0], i[0]);
      @(negedge clk_sys);
      wr_valid = 1'b0;
      check(stalls != 0, 16'h1);
      wait_q(10);
      for (int i = 0; i < 10; i++)
         check(node.got_q.pop_front(), {6'h0, 1'b1, i[0], 8'h10 + i[7:0]});
      check(wr_ready, 16'h1);
   endtask : t_fifo

   task automatic t_shift(input logic m, input int exp);
      int cnt;
      @(negedge clk_sys);
      mode = EU_MODE_SYNC;
      multiproc_enable = m;
      for (int i = 0; i < 40 && shift_clk !== 1'b1; i++) @(negedge clk_sys);
      cnt = 0;
      do begin
         @(negedge clk_sys);
         cnt++;
      end while (shift_clk !== 1'b1 && cnt < 40);
      check(16'(cnt), 16'(exp));
      mode = EU_MODE_FIX11;
      multiproc_enable = 1'b0;
   endtask : t_shift

   // Both timers count up from zero, so their first reload is 65536 counts
   // after reset; the timer-rate modes are exercised only after that
   task automatic t_timer();
      while ($time < 660000) @(negedge clk_sys);
      mode = EU_MODE_VAR11;
      t_tx(1'b0, 8'hc3, 1'b1);
      t_rx(1'b0);
      timer_b_ext_sel = 1'b1;
      t_tx(1'b0, 8'h3d, 1'b0);
      timer_b_ext_sel = 1'b0;
      mode = EU_MODE_VAR10;
      tx_timer_select = 1'b0;
      t_tx(1'b1, 8'h96, 1'b1);
      td_reload = 16'hfffc;
      node.bit_ns = 640;
      multiproc_enable = 1'b1;
      repeat (8) @(negedge clk_sys);
      rx_one(8'h81, 1'b1, {2'b11, 8'h81});
      pulse_clr();
      rx_one(8'h7e, 1'b0, {2'b01, 8'h81});
      multiproc_enable = 1'b0;
   endtask : t_timer

   initial begin
      {rst_b, multiproc_enable, baud_double_bit, tx_timer_select} = 4'h1;
      {tb_reload, td_reload} = 32'hfffe_fffe;
      {rx_timer_select, timer_b_ext_sel, timer_b_pin} = 3'h0;
      {wr_valid, tx_ninth_bit, tx_done_clr, rx_done_clr} = 4'h0;
      {slave_address, slave_address_mask, wr_data} = 24'h0;
      {clk_en, rx_enable, timer_d_tick} = 3'h7;
      mode = EU_MODE_FIX11;
      err_count = 0;
      tests_run = 0;
      stalls = 0;
      repeat (4) @(posedge clk_sys);
      @(negedge clk_sys);
      rst_b = 1'b1;
      repeat (2) @(negedge clk_sys);
      check({txd, tx_done_flag, rx_done_flag, wr_ready, serial_buffer},
            {4'b1001, 8'h00});
      t_tx(1'b1, 8'ha5, 1'b1);
      t_rx(1'b1);
      t_glitch();
      t_multi();
      t_fifo();
      t_tx(1'b0, 8'h6e, 1'b0);
      t_rx(1'b0);
      t_shift(1'b0, 12);
      t_shift(1'b1, 4);
      t_timer();
      report_and_stop();
   end

   // Run is about 71k cycles, mostly the wait for the first timer reload
   initial begin
      #800000;
      err_count++;
      report_and_stop();
   end
endmodule : euart_bench

`default_nettype wire
